// *** common/sdb_pkg.sv ***
// shared constants and types for the sdram burst access block
package sdb_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam int STAT_RD_BIT = 0;
  localparam int STAT_WR_BIT = 1;
  localparam int STAT_IDLE_LSB = 4;
  localparam logic [3:0] IDLE_RST = 4'hf;
  localparam logic [14:0] MODE_RST = 15'h0000;

  // ************************************************************
  // mode register fields
  // ************************************************************
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam int AP_BIT = 10;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int T_WR_NS = 15;
  localparam int LINK_NS = 160;
  localparam int WR_CYC = (T_WR_NS + LINK_NS - 1) / LINK_NS;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_select;
    logic [12:0] a;
    logic [3:0] byte_mask_lanes;
    logic [31:0] dq;
  } sdb_pins_s;

  typedef enum logic [6:0] {
    C_NOP = 7'h01,
    C_ACT = 7'h02,
    C_RD = 7'h04,
    C_WR = 7'h08,
    C_PRE = 7'h10,
    C_BST = 7'h20,
    C_MRS = 7'h40
  } sdb_cmd_e;

  typedef enum logic [2:0] {
    B_IDLE = 3'h1,
    B_RD = 3'h2,
    B_WR = 3'h4
  } sdb_burst_e;
endpackage

// *** core/sdb_core.sv ***
// column access engine of a four bank sdram, with apb status view
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps

// Summary of operation
// - read data after latency, then every clock
// - data lines released when burst ends
// - full page bursts wrap to column zero
// - read byte enables follow mask two clocks earlier
// - reads cut by read, write or precharge
// - first write word taken with command
// - writes cut by write, precharge or read
// - read stops write burst input at once
// - other bank access during auto precharge works
// - read ends auto precharge read, precharge now
// - write ends auto precharge read, precharge now
// - read ends auto precharge write, recovery counted
// - write ends auto precharge write, recovery counted
// - mode write loads bank and address lines
// - burst length code decode, three low bits
// - read latency code decode, bits six-four
// - bit three picks sequential or interleaved
// - bit nine forces single word writes
module sdb_core #(
  parameter int PRE_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sd_clk,
  input wire sdb_pkg::sdb_pins_s sd_in,
  output logic [31:0] dq_o,
  output logic [3:0] dq_oe
);
  localparam logic [PRE_W-1:0] WR_LD = PRE_W'(sdb_pkg::WR_CYC);

  initial begin
    if (PRE_W < 2 || sdb_pkg::WR_CYC >= (1 << PRE_W) ||
        sdb_pkg::WR_CYC < 1) begin
      $error("PRE_W cannot hold the write recovery count");
    end
  end

  // ************************************************************
  // link sampling
  // ************************************************************
  // pins get one stage more than the clock so the pre-edge value
  // is the one taken, as the device registers it at the edge
  sdb_pkg::sdb_pins_s pin_s1_ff, pin_s2_ff, p;
  logic [2:0] clk_sy_ff;
  logic lk_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      p <= '0;
      clk_sy_ff <= 3'h0;
    end else begin
      pin_s1_ff <= sd_in;
      pin_s2_ff <= pin_s1_ff;
      p <= pin_s2_ff;
      clk_sy_ff <= {clk_sy_ff[1:0], sd_clk};
    end
  end

  assign lk_rise = clk_sy_ff[1] & ~clk_sy_ff[2];

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic sdb_pkg::sdb_cmd_e dec(input sdb_pkg::sdb_pins_s s);
    logic [3:0] c;
    c = {s.cs_n, s.ras_n, s.cas_n, s.we_n};
    case (c)
      4'h3: return sdb_pkg::C_ACT;
      4'h5: return sdb_pkg::C_RD;
      4'h4: return sdb_pkg::C_WR;
      4'h2: return sdb_pkg::C_PRE;
      4'h6: return sdb_pkg::C_BST;
      4'h0: return sdb_pkg::C_MRS;
      default: return sdb_pkg::C_NOP;
    endcase
  endfunction

  // word count minus one as a column mask; reserved codes act as 1
  function automatic logic [8:0] blmask(input logic [2:0] code,
                                        input logic one);
    if (one) return 9'h000;
    case (code)
      sdb_pkg::BL_2: return 9'h001;
      sdb_pkg::BL_4: return 9'h003;
      sdb_pkg::BL_8: return 9'h007;
      sdb_pkg::BL_FULL: return 9'h1ff;
      default: return 9'h000;
    endcase
  endfunction

  function automatic logic [8:0] bcol(input logic [8:0] s,
                                      input logic [8:0] i,
                                      input logic [8:0] m,
                                      input logic il);
    if (il) return (s & ~m) | ((s ^ i) & m);
    return (s & ~m) | (9'(s + i) & m);
  endfunction

  // ************************************************************
  // burst engine
  // ************************************************************
  sdb_pkg::sdb_burst_e st_ff, nxt_st, cur_st;
  sdb_pkg::sdb_cmd_e cmd;
  logic [1:0] bank_ff, nxt_bank, cur_bank;
  logic [8:0] col0_ff, nxt_col0, cur_col0;
  logic [8:0] idx_ff, nxt_idx, cur_idx, m;
  logic ap_ff, nxt_ap, cur_ap, full, cl3;
  logic [14:0] mode_ff, nxt_mode, mrs_val;
  logic [3:0] idle_ff, nxt_idle, msk_d_ff, nxt_msk;
  logic [PRE_W-1:0] pre_cnt_ff [4];
  logic [PRE_W-1:0] nxt_pre_cnt [4];
  logic [1:0] pv_ff, nxt_pv;
  logic [10:0] pa_ff [2];
  logic [10:0] nxt_pa [2];
  logic [10:0] new_addr, wr_addr, rd_addr;
  logic out_vld_ff, nxt_out_vld, wr_en, ctrl_en_ff, nxt_ctrl_en;
  logic [31:0] dq_o_ff, nxt_dq_o;
  logic [3:0] oe_ff, nxt_oe, wr_be;
  logic [31:0] mem [2048];

  assign cmd = ctrl_en_ff ? dec(p) : sdb_pkg::C_NOP;
  assign mrs_val = {p.bank_select, p.a};
  assign new_addr = {p.bank_select, p.a[8:0]};
  assign cl3 = mode_ff[sdb_pkg::MODE_CL_LSB +: 3] == sdb_pkg::CL_3;
  assign rd_addr = cl3 ? pa_ff[1] : pa_ff[0];

  always_comb begin
    nxt_st = st_ff;
    nxt_bank = bank_ff;
    nxt_col0 = col0_ff;
    nxt_idx = idx_ff;
    nxt_ap = ap_ff;
    nxt_mode = mode_ff;
    nxt_idle = idle_ff;
    nxt_msk = msk_d_ff;
    nxt_pre_cnt = pre_cnt_ff;
    nxt_pv = pv_ff;
    nxt_pa = pa_ff;
    nxt_out_vld = out_vld_ff;
    nxt_dq_o = dq_o_ff;
    nxt_oe = oe_ff;
    cur_st = st_ff;
    cur_bank = bank_ff;
    cur_col0 = col0_ff;
    cur_idx = idx_ff;
    cur_ap = ap_ff;
    wr_en = 1'b0;
    wr_addr = 11'h000;
    wr_be = 4'h0;
    m = 9'h000;
    full = 1'b0;
    if (lk_rise) begin
      nxt_msk = p.byte_mask_lanes;
      for (int b = 0; b < 4; b++) begin
        if (pre_cnt_ff[b] != '0) begin
          nxt_pre_cnt[b] = pre_cnt_ff[b] - 1'b1;
          if (pre_cnt_ff[b] == PRE_W'(1)) nxt_idle[b] = 1'b1;
        end
      end
      if (cmd == sdb_pkg::C_RD || cmd == sdb_pkg::C_WR) begin
        // other bank access ends an auto precharge burst early
        if (st_ff != sdb_pkg::B_IDLE && ap_ff &&
            p.bank_select != bank_ff) begin
          if (st_ff == sdb_pkg::B_RD) nxt_idle[bank_ff] = 1'b1;
          else nxt_pre_cnt[bank_ff] = WR_LD;
        end
        cur_st = (cmd == sdb_pkg::C_RD) ? sdb_pkg::B_RD : sdb_pkg::B_WR;
        cur_bank = p.bank_select;
        cur_col0 = p.a[8:0];
        cur_idx = 9'h000;
        cur_ap = p.a[sdb_pkg::AP_BIT];
      end else if (cmd == sdb_pkg::C_BST && !ap_ff) begin
        cur_st = sdb_pkg::B_IDLE;
      end else if (cmd == sdb_pkg::C_PRE) begin
        if (p.a[sdb_pkg::AP_BIT]) nxt_idle = 4'hf;
        else nxt_idle[p.bank_select] = 1'b1;
        if (p.a[sdb_pkg::AP_BIT] || p.bank_select == bank_ff) begin
          cur_st = sdb_pkg::B_IDLE;
        end
      end else if (cmd == sdb_pkg::C_ACT) begin
        nxt_idle[p.bank_select] = 1'b0;
      end else if (cmd == sdb_pkg::C_MRS) begin
        nxt_mode = mrs_val;
      end
      m = blmask(mode_ff[sdb_pkg::MODE_BL_LSB +: 3],
                 cur_st == sdb_pkg::B_WR && mode_ff[sdb_pkg::MODE_WB_BIT]);
      full = m == 9'h1ff && !(cur_st == sdb_pkg::B_WR &&
                              mode_ff[sdb_pkg::MODE_WB_BIT]);
      nxt_pa[0] = {cur_bank, bcol(cur_col0, cur_idx, m,
                                  mode_ff[sdb_pkg::MODE_BT_BIT])};
      nxt_pa[1] = pa_ff[0];
      nxt_pv = {pv_ff[0], cur_st == sdb_pkg::B_RD};
      if (cur_st == sdb_pkg::B_WR) begin
        wr_en = 1'b1;
        wr_addr = nxt_pa[0];
        wr_be = ~p.byte_mask_lanes;
      end
      unique case (cur_st)
        sdb_pkg::B_IDLE: nxt_st = sdb_pkg::B_IDLE;
        sdb_pkg::B_RD, sdb_pkg::B_WR: begin
          nxt_st = cur_st;
          if (!full && cur_idx == m) begin
            nxt_st = sdb_pkg::B_IDLE;
            if (cur_ap && cur_st == sdb_pkg::B_RD) nxt_idle[cur_bank] = 1'b1;
            if (cur_ap && cur_st == sdb_pkg::B_WR) nxt_pre_cnt[cur_bank] = WR_LD;
          end
        end
      endcase
      nxt_bank = cur_bank;
      nxt_col0 = cur_col0;
      nxt_idx = 9'(cur_idx + 9'h001);
      nxt_ap = cur_ap;
      // words leave the pipe one link edge before the sampling edge
      nxt_out_vld = cl3 ? pv_ff[1] : pv_ff[0];
      nxt_dq_o = mem[rd_addr];
      nxt_oe = nxt_out_vld ? ~msk_d_ff : 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= sdb_pkg::B_IDLE;
      bank_ff <= 2'h0;
      col0_ff <= 9'h000;
      idx_ff <= 9'h000;
      ap_ff <= 1'b0;
      mode_ff <= sdb_pkg::MODE_RST;
      idle_ff <= sdb_pkg::IDLE_RST;
      msk_d_ff <= 4'h0;
      pre_cnt_ff <= '{default: '0};
      pv_ff <= 2'h0;
      pa_ff <= '{default: '0};
      out_vld_ff <= 1'b0;
      dq_o_ff <= 32'h0;
      oe_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      bank_ff <= nxt_bank;
      col0_ff <= nxt_col0;
      idx_ff <= nxt_idx;
      ap_ff <= nxt_ap;
      mode_ff <= nxt_mode;
      idle_ff <= nxt_idle;
      msk_d_ff <= nxt_msk;
      pre_cnt_ff <= nxt_pre_cnt;
      pv_ff <= nxt_pv;
      pa_ff <= nxt_pa;
      out_vld_ff <= nxt_out_vld;
      dq_o_ff <= nxt_dq_o;
      oe_ff <= nxt_oe;
    end
  end

  // array contents are not reset, like the real cells
  always_ff @(posedge pclk) begin
    for (int k = 0; k < 4; k++) begin
      if (wr_en && wr_be[k]) mem[wr_addr][8*k +: 8] <= p.dq[8*k +: 8];
    end
  end

  assign dq_o = dq_o_ff;
  assign dq_oe = oe_ff;

  // ************************************************************
  // apb slave
  // ************************************************************
  logic [31:0] prdata_ff, nxt_prdata, stat;
  logic hit;

  assign hit = paddr == sdb_pkg::ADDR_CTRL || paddr == sdb_pkg::ADDR_MODE ||
               paddr == sdb_pkg::ADDR_STAT;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    stat = 32'h0;
    stat[sdb_pkg::STAT_RD_BIT] = st_ff == sdb_pkg::B_RD;
    stat[sdb_pkg::STAT_WR_BIT] = st_ff == sdb_pkg::B_WR;
    stat[sdb_pkg::STAT_IDLE_LSB +: 4] = idle_ff;
    nxt_ctrl_en = ctrl_en_ff;
    nxt_prdata = prdata_ff;
    if (psel && penable && pwrite && paddr == sdb_pkg::ADDR_CTRL) begin
      nxt_ctrl_en = pwdata[sdb_pkg::CTRL_EN_BIT];
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        sdb_pkg::ADDR_CTRL: nxt_prdata = {31'h0, ctrl_en_ff};
        sdb_pkg::ADDR_MODE: nxt_prdata = {17'h0, mode_ff};
        sdb_pkg::ADDR_STAT: nxt_prdata = stat;
        default: nxt_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff <= sdb_pkg::CTRL_EN_RST;
      prdata_ff <= 32'h0;
    end else begin
      ctrl_en_ff <= nxt_ctrl_en;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_mrs;
    (lk_rise && cmd == sdb_pkg::C_MRS) |=> mode_ff == $past(mrs_val);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode load wrong");

  property p_rd_start;
    (lk_rise && cmd == sdb_pkg::C_RD) |=>
      st_ff == sdb_pkg::B_RD && pv_ff[0] && pa_ff[0] == $past(new_addr);
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start");

  property p_wr_first;
    (lk_rise && cmd == sdb_pkg::C_WR) |-> wr_en && wr_addr == new_addr;
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("first word");

  property p_rd_stops_wr;
    (lk_rise && cmd == sdb_pkg::C_RD) |-> !wr_en ##1 st_ff != sdb_pkg::B_WR;
  endproperty
  a_rd_stops_wr: assert property (p_rd_stops_wr) else $error("wr kept");

  property p_hiz;
    !out_vld_ff |-> dq_oe == 4'h0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("bus not released");

  property p_mask;
    (lk_rise && msk_d_ff == 4'hf) |=> dq_oe == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("mask latency");

  property p_wrap;
    (lk_rise && cmd == sdb_pkg::C_NOP && st_ff == sdb_pkg::B_RD &&
     mode_ff[2:0] == sdb_pkg::BL_FULL && idx_ff == 9'h1ff) |=>
      st_ff == sdb_pkg::B_RD && idx_ff == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("page wrap");

  property p_rd_ap_rd;
    (lk_rise && cmd == sdb_pkg::C_RD && st_ff == sdb_pkg::B_RD && ap_ff &&
     p.bank_select != bank_ff) |=> idle_ff[$past(bank_ff)];
  endproperty
  a_rd_ap_rd: assert property (p_rd_ap_rd) else $error("rd ap");

  property p_wr_ap_wr;
    (lk_rise && cmd == sdb_pkg::C_WR && st_ff == sdb_pkg::B_WR && ap_ff &&
     p.bank_select != bank_ff) |=> pre_cnt_ff[$past(bank_ff)] == WR_LD;
  endproperty
  a_wr_ap_wr: assert property (p_wr_ap_wr) else $error("wr ap");

  property p_single;
    (lk_rise && cmd == sdb_pkg::C_WR && mode_ff[sdb_pkg::MODE_WB_BIT]) |=>
      st_ff == sdb_pkg::B_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single write");
endmodule // sdb_core

// *** sim/sdb_ctl_model.sv ***
// link side model: memory controller driving the sdram pins
`timescale 1ns/10ps
module sdb_ctl_model (
  output logic sd_clk,
  output sdb_pkg::sdb_pins_s sd_in,
  input wire logic [31:0] dq_o,
  input wire logic [3:0] dq_oe
);
  // ********
  // link clock
  // ********
  // runs free as on a real board, phase unrelated to pclk
  initial begin
    sd_clk = 1'b0;
    sd_in = {4'hf, 51'h0};
    #3.3;
    forever #80 sd_clk = ~sd_clk;
  end

  // ********
  // one link cycle
  // ********
  // released data lines toggle so stale data never looks valid
  task automatic cyc(input logic [3:0] c, input logic [1:0] b,
    input logic [12:0] a, input logic [3:0] m, input logic dv,
    input logic [31:0] d, output logic [31:0] q, output logic [3:0] e);
    @(posedge sd_clk);
    q = dq_o;
    e = dq_oe;
    sd_in <= {c, b, a, m, dv ? d : ~sd_in.dq};
  endtask
endmodule // sdb_ctl_model

// *** sim/sdb_core_tb_top.sv ***
// self-checking bench for the apb view and link bursts of sdb_core
`timescale 1ns/10ps
module sdb_core_tb_top;
  // ********
  // plumbing
  // ********
  localparam logic [3:0] NOP = 4'h7;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] RD = 4'h5;
  localparam logic [3:0] WR = 4'h4;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] BST = 4'h6;
  localparam logic [3:0] MRS = 4'h0;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sd_clk, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dq_o, q, r;
  logic [3:0] dq_oe, oe;
  sdb_pkg::sdb_pins_s sd_in;
  logic [31:0] mem [4][512];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc_n = 0;

  sdb_core sdb_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sd_clk(sd_clk),
    .sd_in(sd_in), .dq_o(dq_o), .dq_oe(dq_oe));
  sdb_ctl_model sdb_ctl_model_i (.sd_clk(sd_clk), .sd_in(sd_in),
    .dq_o(dq_o), .dq_oe(dq_oe));

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 10000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] ln(input logic [3:0] e);
    return {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
  endfunction

  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 64);
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // ********
  // link helpers, bursts all on bank 1
  // ********
  task automatic lk(input logic [3:0] c, input logic [1:0] b,
    input logic [12:0] a, input logic [3:0] m, input logic dv,
    input logic [31:0] d);
    sdb_ctl_model_i.cyc(c, b, a, m, dv, d, q, oe);
  endtask

  task automatic nop(input int n);
    repeat (n) lk(NOP, 0, 0, 0, 0, 0);
  endtask

  // mode changes only with every bank closed
  task automatic mrs(input logic [14:0] v);
    nop(1);
    lk(PRE, 0, 13'h0400, 0, 0, 0);
    nop(1);
    lk(MRS, v[14:13], v[12:0], 0, 0, 0);
    nop(2);
    lk(ACT, 1, 0, 0, 0, 0);
    nop(2);
  endtask

  task automatic wr(input logic [8:0] c, input int n,
    input logic [31:0] d, input logic [3:0] k);
    for (int i = 0; i < n; i++) begin
      lk(i == 0 ? WR : NOP, 1, {4'h0, c}, 0, 1, d + i);
      mem[1][9'(c + i)] = d + i;
    end
    lk(k, 1, 0, 0, 0, 0);
    nop(1);
  endtask

  // mw: mask call index, k2: call of a second read at column 4
  task automatic rd(input logic [8:0] c1, input int l, input int n,
    input logic il, input int mw, input int k2, input logic [3:0] k);
    logic [8:0] c;
    logic [3:0] e;
    int i;
    lk(RD, 1, {4'h0, c1}, 0, 0, 0);
    for (int j = 1; j <= l + n + 1; j++) begin
      lk(j == k2 ? RD : (j == n ? k : NOP), 1, 13'h0004,
        j == mw ? 4'h1 : 4'h0, 0, 0);
      i = j - 1 - l;
      c = il ? c1 ^ 9'(i) : 9'(c1 + i);
      if (k2 > 0 && i >= k2)
        c = 9'(4 + i - k2);
      e = (mw > 0 && i == mw + 2 - l) ? 4'he : 4'hf;
      if (i < 0 || i >= n)
        e = 4'h0;
      chk("dq_oe", {28'h0, e}, {28'h0, oe});
      if (e != 4'h0)
        chk("dq_o", mem[1][c] & ln(e), q & ln(e));
    end
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_regs();
    apb(0, 8'h00, 0);
    chk("ctrl", 32'h1, r);
    apb(0, 8'h04, 0);
    chk("mode", 32'h0, r);
    apb(0, 8'h08, 0);
    chk("stat", {24'h0, sdb_pkg::IDLE_RST, 4'h0}, r);
    apb(1, 8'h0c, 32'h1);
    chk("pslverr", 32'h1, {31'h0, er});
    apb(0, 8'h0c, 0);
    chk("unmapped", 32'h0, r);
    apb(1, 8'h00, 0);
    apb(0, 8'h00, 0);
    chk("ctrl", 32'h0, r);
    apb(1, 8'h00, 32'h1);
  endtask

  task automatic t_mode();
    mrs(15'h4022);
    apb(0, 8'h04, 0);
    chk("mode", 32'h4022, r);
  endtask

  // write cuts a read whose words are all masked off
  task automatic t_rd_wr();
    lk(RD, 1, 13'h0004, 4'hf, 0, 0);
    lk(NOP, 1, 0, 4'hf, 0, 0);
    chk("dq_oe", 32'h0, {28'h0, oe});
    lk(WR, 1, 13'h0004, 0, 1, 32'h5555_0000);
    chk("dq_oe", 32'h0, {28'h0, oe});
    lk(NOP, 1, 0, 0, 1, 32'h5555_0001);
    chk("dq_oe", 32'h0, {28'h0, oe});
    lk(PRE, 1, 0, 4'hf, 0, 0);
    chk("dq_oe", 32'h0, {28'h0, oe});
    lk(NOP, 1, 0, 0, 0, 0);
    chk("dq_oe", 32'h0, {28'h0, oe});
    mem[1][4] = 32'h5555_0000;
    mem[1][5] = 32'h5555_0001;
    lk(ACT, 1, 0, 0, 0, 0);
    nop(2);
    rd(4, 2, 4, 0, 0, 0, NOP);
  endtask

  task automatic t_single();
    logic [31:0] sv [3];
    for (int i = 0; i < 3; i++)
      sv[i] = mem[1][i + 5];
    mrs(15'h0222);
    wr(4, 4, 32'h4444_0000, NOP);
    for (int i = 0; i < 3; i++)
      mem[1][i + 5] = sv[i];
    rd(4, 2, 4, 0, 0, 0, NOP);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    nop(3);
    t_mode();
    wr(4, 4, 32'h1111_0000, NOP);
    rd(4, 2, 4, 0, 2, 0, NOP);
    mrs(15'h0032);
    rd(4, 3, 4, 0, 0, 0, NOP);
    mrs(15'h0027);
    wr(9'd510, 3, 32'h2222_0000, BST);
    rd(9'd510, 2, 3, 0, 0, 0, BST);
    mrs(15'h002a);
    rd(5, 2, 4, 1, 0, 0, NOP);
    mrs(15'h0022);
    rd(4, 2, 5, 0, 0, 1, NOP);
    lk(WR, 1, 13'h0004, 0, 1, 32'h3333_0000);
    mem[1][4] = 32'h3333_0000;
    rd(4, 2, 4, 0, 0, 0, NOP);
    t_rd_wr();
    t_single();
    end_of_test();
  end
endmodule // sdb_core_tb_top
